// ==== design/fault_log_defines.svh ====
// Offsets, field positions, reset values and counts of the fault flag
// and fault log configuration bank. Definitions only.
`ifndef FAULT_LOG_DEFINES_SVH
`define FAULT_LOG_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_FAULT_FLAGS_HIGH 8'h1C
`define OFS_SECONDARY_FAILURE_SLOT 8'h1D
`define OFS_FAULT_LOG_CONTENT_SELECT 8'h6D
`define OFS_UV_CRITICAL_ENABLE_LOW 8'h6E
`define OFS_UV_OV_CRITICAL_ENABLE_MIXED 8'h6F
`define OFS_LOG_LOCK 8'h8C

// ****************************************************************
// Field positions
// ****************************************************************
`define FLAG_OVERCURRENT_BIT 4
`define FLAG_EXTERNAL_FAULT_BIT 5
`define FLAG_BUS_ALERT_BIT 6
`define CFG_EXT_TRIGGER_BIT 2
`define LOCK_BIT 1
`define SEL_NOTHING 2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FLAGS 7'h00
`define RST_SLOT 5'h00
`define RST_LOG_CFG 3'h0
`define RST_ENABLE 8'h00

// ****************************************************************
// Log layout and counts
// ****************************************************************
`define LOG_BYTES 16
`define LOG_LAST_IDX 4'hF
`define LOG_IDX_SLOT 4'h0
`define LOG_IDX_FLAGS_LOW 4'h1
`define LOG_IDX_FLAGS_HIGH 4'h2
`define LOG_IDX_ADC_FIRST 4'h3
`define LOG_IDX_ADC_LAST 4'hE
`define INPUT_COUNT 12
`define ADC_BITS 10

`endif

// ==== design/fault_log_pkg.sv ====
// Types shared by the fault flag and log configuration bank.
// Assumes the defines header is compiled alongside.
package fault_log_pkg;

  typedef enum logic [1:0] {
    LOG_IDLE = 2'b00,
    LOG_WRITE = 2'b01,
    LOG_LOCKED = 2'b10
  } log_state_t;

endpackage : fault_log_pkg

// ==== design/fault_log_store.sv ====
// Sixteen-byte fault log store with one write port and a registered read.
// Assumes both ports in the ref_clk_in domain.
`timescale 1ns/1ps
`default_nettype none
`include "fault_log_defines.svh"

module fault_log_store (
  input wire logic ref_clk_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [3:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem_q [0:`LOG_BYTES-1];

  // No reset: content is only meaningful after a log has been written
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule : fault_log_store
`default_nettype wire

// ==== design/fault_flag_and_log_config.sv ====
// Fault flag registers, secondary failure slot, critical fault log
// configuration and the log writer of a supply monitor.
// Assumes all inputs synchronous to ref_clk_in; the serial interface
// presents one register access per strobe on the reg_* port.
//
// Function
// RULE1: fault_flags_high: inputs 9-12 in bits 3:0, overcurrent 4, external fault 5, bus alert 6.
// RULE2: A secondary failure stores its slot in read-only secondary_failure_slot[4:0], rest zero.
// RULE3: fault_log_content_select[1:0] picks flags plus values, flags, values or nothing to log.
// RULE4: fault_log_content_select[2] makes a low external fault line log; bits 7:3 unused.
// RULE5: Bit n of undervoltage_critical_enable_low makes input n+1 undervoltage a critical fault.
// RULE6: uv_ov_critical_enable_mixed[3:0] make inputs 9-12 undervoltage a critical fault.
// RULE7: uv_ov_critical_enable_mixed[7:4] make inputs 1-4 overvoltage a critical fault.
// RULE8: A flag sets only when its enable is set, and writing one clears it; the overcurrent and bus alert flags here have no enable.
// RULE9: A stored log locks the log memory until software writes zero to bit 1 of the lock register.
// RULE10: Every converter result in the log is stored as eight bits.
// RULE11: Flags stay set until cleared, and bit 7 of fault_flags_high reads as zero.
`timescale 1ns/1ps
`default_nettype none
`include "fault_log_defines.svh"

module fault_flag_and_log_config
  import fault_log_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [11:0] monitored_input_uv_in,
  input wire logic [3:0] monitored_input_ov_in,
  input wire logic overcurrent_in,
  input wire logic external_fault_line_low_in,
  input wire logic bus_alert_in,
  input wire logic secondary_fail_in,
  input wire logic [4:0] secondary_slot_in,
  input wire logic [4:0] sequencer_state_in,
  input wire logic [119:0] adc_values_in,
  input wire logic [3:0] log_rd_addr_in,
  output logic [7:0] log_rd_data_out,
  output logic log_busy_out,
  output logic log_locked_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [6:0] flags_q, flags_d;
  logic [4:0] slot_q;
  logic [2:0] log_cfg_q;
  logic [7:0] en_low_q;
  logic [7:0] en_mixed_q;
  log_state_t state_q, state_d;
  logic [3:0] idx_q;
  logic locked_q;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  wire wr_flags = reg_wr_in && hit(reg_addr_in, `OFS_FAULT_FLAGS_HIGH);
  wire wr_cfg = reg_wr_in && hit(reg_addr_in, `OFS_FAULT_LOG_CONTENT_SELECT);
  wire wr_en_low = reg_wr_in && hit(reg_addr_in, `OFS_UV_CRITICAL_ENABLE_LOW);
  wire wr_en_mixed = reg_wr_in && hit(reg_addr_in, `OFS_UV_OV_CRITICAL_ENABLE_MIXED);
  wire unlock_wr = reg_wr_in && hit(reg_addr_in, `OFS_LOG_LOCK) && !reg_wdata_in[`LOCK_BIT];

  // ****************************************************************
  // Critical fault sources
  // ****************************************************************
  wire [7:0] crit_low = monitored_input_uv_in[7:0] & en_low_q; // RULE5
  wire [3:0] crit_uv_high = monitored_input_uv_in[11:8] & en_mixed_q[3:0]; // RULE6
  wire [3:0] crit_ov = monitored_input_ov_in & en_mixed_q[7:4]; // RULE7
  wire crit_ext = external_fault_line_low_in && log_cfg_q[`CFG_EXT_TRIGGER_BIT]; // RULE4
  wire critical = |{crit_low, crit_uv_high, crit_ov, crit_ext};
  wire [1:0] sel = log_cfg_q[1:0];
  wire log_start = (state_q == LOG_IDLE) && !locked_q && critical && (sel != `SEL_NOTHING);

  // Input and external fault flags set only through their enables, overcurrent and bus alert directly; set wins over the write-one clear
  wire [6:0] flag_set = {bus_alert_in, crit_ext, overcurrent_in, crit_uv_high}; // RULE1 RULE8
  wire [6:0] flag_clr = wr_flags ? reg_wdata_in[6:0] : 7'h00; // RULE8
  assign flags_d = (flags_q & ~flag_clr) | flag_set; // RULE11

  // ****************************************************************
  // Log byte selection
  // ****************************************************************
  logic [7:0] adc8 [0:`INPUT_COUNT-1];
  genvar g;
  generate
    for (g = 0; g < `INPUT_COUNT; g++) begin : g_adc
      // Upper eight bits of the 10-bit result; the two LSBs are dropped
      assign adc8[g] = adc_values_in[g*`ADC_BITS+2 +: 8]; // RULE10
    end
  endgenerate

  wire save_flags = !sel[1]; // RULE3
  wire save_adc = !sel[0]; // RULE3
  wire idx_is_adc = (idx_q >= `LOG_IDX_ADC_FIRST) && (idx_q <= `LOG_IDX_ADC_LAST);
  wire [3:0] adc_sel = idx_q - `LOG_IDX_ADC_FIRST;
  wire [7:0] flags_low_byte = crit_low | {4'h0, crit_ov};
  wire [7:0] log_byte =
    (idx_q == `LOG_IDX_SLOT) ? {3'h0, sequencer_state_in} :
    (idx_q == `LOG_IDX_FLAGS_LOW) ? (save_flags ? flags_low_byte : 8'h00) :
    (idx_q == `LOG_IDX_FLAGS_HIGH) ? (save_flags ? {1'b0, flags_q} : 8'h00) :
    (idx_is_adc && save_adc) ? adc8[adc_sel] : 8'h00;
  wire log_wr = (state_q == LOG_WRITE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      LOG_IDLE: begin
        if (log_start) begin
          state_d = LOG_WRITE;
        end
      end
      LOG_WRITE: begin
        if (idx_q == `LOG_LAST_IDX) begin
          state_d = LOG_LOCKED;
        end
      end
      LOG_LOCKED: begin
        if (unlock_wr) begin
          state_d = LOG_IDLE;
        end
      end
      default: state_d = LOG_IDLE;
    endcase
  end

  // Register read mux; reserved bits read zero
  wire [7:0] rd_mux =
    hit(reg_addr_in, `OFS_FAULT_FLAGS_HIGH) ? {1'b0, flags_q} : // RULE11
    hit(reg_addr_in, `OFS_SECONDARY_FAILURE_SLOT) ? {3'h0, slot_q} : // RULE2
    hit(reg_addr_in, `OFS_FAULT_LOG_CONTENT_SELECT) ? {5'h00, log_cfg_q} : // RULE4
    hit(reg_addr_in, `OFS_UV_CRITICAL_ENABLE_LOW) ? en_low_q :
    hit(reg_addr_in, `OFS_UV_OV_CRITICAL_ENABLE_MIXED) ? en_mixed_q :
    hit(reg_addr_in, `OFS_LOG_LOCK) ? {6'h00, locked_q, 1'b0} : 8'h00;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      flags_q <= `RST_FLAGS;
      slot_q <= `RST_SLOT;
      log_cfg_q <= `RST_LOG_CFG;
      en_low_q <= `RST_ENABLE;
      en_mixed_q <= `RST_ENABLE;
    end else begin
      flags_q <= flags_d; // RULE8
      if (secondary_fail_in) slot_q <= secondary_slot_in; // RULE2
      if (wr_cfg) log_cfg_q <= reg_wdata_in[2:0]; // RULE3
      if (wr_en_low) en_low_q <= reg_wdata_in; // RULE5
      if (wr_en_mixed) en_mixed_q <= reg_wdata_in; // RULE6 RULE7
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q <= LOG_IDLE;
      idx_q <= 4'h0;
      locked_q <= 1'b0;
      log_busy_out <= 1'b0;
      log_locked_out <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else begin
      state_q <= state_d;
      idx_q <= log_wr ? idx_q + 4'h1 : 4'h0;
      // Lock after the last byte; an unlock in that same cycle loses
      locked_q <= (state_d == LOG_LOCKED); // RULE9
      log_busy_out <= (state_d == LOG_WRITE);
      log_locked_out <= (state_d == LOG_LOCKED);
      if (reg_rd_in) reg_rdata_out <= rd_mux;
    end
  end

  fault_log_store u_store (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(log_wr),
    .wr_addr_in(idx_q),
    .wr_data_in(log_byte),
    .rd_addr_in(log_rd_addr_in),
    .rd_data_out(log_rd_data_out)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  uv_flag_set_a: assert property (monitored_input_uv_in[8] && en_mixed_q[0] |=> flags_q[0]) // RULE6
    else $error("input 9 flag not set");
  flag_gated_a: assert property ($rose(flags_q[1]) |-> $past(monitored_input_uv_in[9] && en_mixed_q[1])) // RULE8
    else $error("flag set without enable");
  flag_clear_a: assert property (wr_flags && reg_wdata_in[6] && !bus_alert_in |=> !flags_q[6]) // RULE8
    else $error("write one did not clear");
  flag_sticky_a: assert property (flags_q[4] && !(wr_flags && reg_wdata_in[4]) |=> flags_q[4]) // RULE11
    else $error("flag dropped by itself");
  reserved_zero_a: assert property (reg_rd_in && hit(reg_addr_in, `OFS_FAULT_FLAGS_HIGH) |=> !reg_rdata_out[7]) // RULE11
    else $error("reserved flag bit set");
  slot_capture_a: assert property (secondary_fail_in |=> slot_q == $past(secondary_slot_in)) // RULE2
    else $error("slot not captured");
  log_off_a: assert property (state_q == LOG_IDLE && sel == `SEL_NOTHING |=> state_q == LOG_IDLE) // RULE3
    else $error("log started while off");
  ext_trigger_a: assert property (log_start && crit_ext |=> log_busy_out ##16 log_locked_out) // RULE4 RULE9
    else $error("external fault log sequence wrong");
  uv_trigger_a: assert property (state_q == LOG_IDLE && !locked_q && sel != `SEL_NOTHING // RULE5
    && |crit_low |=> state_q == LOG_WRITE)
    else $error("undervoltage log not started");
  ov_trigger_a: assert property (state_q == LOG_IDLE && !locked_q && sel == 2'h0 // RULE7
    && |crit_ov |=> state_q == LOG_WRITE)
    else $error("overvoltage log not started");
  lock_hold_a: assert property (locked_q && !unlock_wr |=> locked_q && !log_wr) // RULE9
    else $error("lock released without unlock");
  // Checked against the raw input bus so a wrong slice in the byte selector shows up
  adc_byte_a: assert property (log_wr && idx_is_adc && save_adc |-> // RULE10
    log_byte == adc_values_in[adc_sel*`ADC_BITS+2 +: 8])
    else $error("converter byte wrong");

  log_cycle_c: cover property (log_start ##17 locked_q ##[1:20] unlock_wr);
  flag_clear_c: cover property (flags_q[5] ##1 wr_flags ##1 !flags_q[5]);
  flags_only_c: cover property (log_start && sel == 2'h1);

endmodule : fault_flag_and_log_config
`default_nettype wire

// ==== tb/host_model.sv ====
// Host software model: single-byte register accesses on the strobe port.
// Assumes a free-running clock; every request is launched on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One strobe per access, then an idle cycle so no strobe is set twice at one edge
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
  endtask : access
endmodule : host_model
`default_nettype wire

// ==== tb/tb_fault_flag_and_log_config.sv ====
// Self-checking bench of the fault flag and log configuration bank.
// Assumes the design package and defines header are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_fault_flag_and_log_config;
  logic ref_clk, resetn, wr, rd, oc, ext, alert, sfail, busy, locked;
  logic rd_seen = 1'b0;
  logic [7:0] addr, wdata, rdata, log_data, e;
  logic [11:0] uv;
  logic [3:0] ov, log_addr;
  logic [4:0] slot, state;
  logic [119:0] adc;
  logic [7:0] exp_q[$];
  logic [7:0] ofs [7] = '{8'h1C, 8'h1D, 8'h6D, 8'h6E, 8'h6F, 8'h8C, 8'h33};
  int n_errors = 0;
  int comparisons = 0;
  int w;

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  fault_flag_and_log_config dut (.ref_clk_in(ref_clk), .resetn_in(resetn),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .monitored_input_uv_in(uv), .monitored_input_ov_in(ov),
    .overcurrent_in(oc), .external_fault_line_low_in(ext), .bus_alert_in(alert),
    .secondary_fail_in(sfail), .secondary_slot_in(slot), .sequencer_state_in(state),
    .adc_values_in(adc), .log_rd_addr_in(log_addr), .log_rd_data_out(log_data),
    .log_busy_out(busy), .log_locked_out(locked));

  host_model host (.clk_in(ref_clk), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
    .rd_out(rd));

  // ****************************************************************
  // Compare and access tasks
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host.access(a, 8'h00, 1'b0);
  endtask : rd_exp

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.access(a, d, 1'b1);
  endtask : wr_reg

  task automatic log_byte(input logic [3:0] i, input logic [7:0] x);
    @(negedge ref_clk);
    log_addr = i;
    repeat (2) @(negedge ref_clk);
    check(log_data, x);
  endtask : log_byte

  task automatic results;
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Read data lands one cycle after the strobe; the oldest note is its expectation
  always @(posedge ref_clk) rd_seen <= rd;
  always @(negedge ref_clk) begin
    if (rd_seen) begin
      check(rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(58363));
    resetn = 1'b0;
    {oc, ext, alert, sfail} = 4'h0;
    uv = 12'h000;
    ov = 4'h0;
    log_addr = 4'h0;
    slot = 5'($urandom());
    state = 5'($urandom());
    for (int k = 0; k < 4; k++) begin
      adc[k*30 +: 30] = 30'($urandom());
    end
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    foreach (ofs[i]) rd_exp(ofs[i], 8'h00);
    e = 8'($urandom());
    wr_reg(8'h6E, e);
    rd_exp(8'h6E, e);
    wr_reg(8'h6F, ~e);
    rd_exp(8'h6F, ~e);
    wr_reg(8'h6D, 8'hFF);
    rd_exp(8'h6D, 8'h07);
    wr_reg(8'h6E, 8'h00);
    @(negedge ref_clk);
    sfail = 1'b1;
    @(negedge ref_clk);
    sfail = 1'b0;
    wr_reg(8'h1D, 8'hFF);
    rd_exp(8'h1D, {3'b000, slot});
    // Only input 9 is enabled, so input 10 must stay clear; code 11 must not log
    wr_reg(8'h6F, 8'h01);
    @(negedge ref_clk);
    {oc, ext, alert} = 3'b111;
    uv[9:8] = 2'b11;
    repeat (2) @(negedge ref_clk);
    {oc, ext, alert} = 3'b000;
    uv = 12'h000;
    rd_exp(8'h1C, 8'h71);
    check({6'h00, busy, locked}, 8'h00);
    wr_reg(8'h1C, 8'h11);
    rd_exp(8'h1C, 8'h60);
    wr_reg(8'h1C, 8'hFF);
    rd_exp(8'h1C, 8'h00);
    for (int c = 0; c < 3; c++) begin
      wr_reg(8'h6D, {5'h00, c == 2, 2'(c)});
      wr_reg(8'h6E, {7'h00, c == 0});
      wr_reg(8'h6F, {3'h0, c == 1, 4'h0});
      @(negedge ref_clk);
      uv[0] = (c == 0);
      ov[0] = (c == 1);
      ext = (c == 2);
      repeat (2) @(negedge ref_clk);
      check({7'h00, busy}, 8'h01);
      w = 0;
      while (locked !== 1'b1 && w < 40) begin
        @(negedge ref_clk);
        w++;
      end
      uv = 12'h000;
      ov = 4'h0;
      ext = 1'b0;
      check({6'h00, busy, locked}, 8'h01);
      log_byte(4'h0, {3'b000, state});
      log_byte(4'h1, (c == 2) ? 8'h00 : 8'h01);
      log_byte(4'h3, (c == 1) ? 8'h00 : adc[9:2]);
      log_byte(4'hF, 8'h00);
      rd_exp(8'h8C, 8'h02);
      wr_reg(8'h8C, 8'h00);
      rd_exp(8'h8C, 8'h00);
    end
    repeat (4) @(negedge ref_clk);
    results();
  end
endmodule : tb_fault_flag_and_log_config
`default_nettype wire
